// ==== verilog/crt_rtc.sv ====
// Calendar clock with prescalers, event flags and AHB-Lite registers
`timescale 1ns/1ps
module crt_rtc (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Low-frequency reference pin
  input wire logic oscClk,
  // Processor interrupt
  output logic rtcIrq
);

  crt_pkg::crt_state_t q;
  crt_pkg::crt_state_t d;
  crt_pkg::crt_flags_t setF;
  crt_pkg::crt_flags_t clrF;
  logic hold;
  logic calMode;
  logic bcd;
  logic oscTick;
  logic psTick;
  logic ps0Evt;
  logic ps1Evt;
  logic ps0Ovf;
  logic [7:0] ps0Cnt;
  logic [7:0] ps1Cnt;
  logic secTick;
  logic psLoad;
  logic minEdge;
  logic hourEdge;
  logic almHit;
  logic almAny;
  logic addrPh;
  logic wrEn;
  logic [7:0] fMin;
  logic [7:0] fHour;
  logic [7:0] fDow;
  logic [7:0] fDom;

  assign hold = q.ctrl[crt_pkg::CTRL_HOLD];
  assign calMode = !q.ctrl[crt_pkg::CTRL_MODE];
  assign bcd = q.ctrl[crt_pkg::CTRL_BCD];
  assign oscTick = q.osc2 && !q.oscPrev;
  // Hold gates the root tick, so every stage behind it freezes
  assign psTick = oscTick && !hold;
  assign secTick = ps0Ovf && (ps1Cnt[6:0] == crt_pkg::SEC_MASK);
  assign addrPh = hsel && htrans[1] && hready;
  assign wrEn = q.dphWr;
  assign psLoad = wrEn && (q.dphAddr == crt_pkg::OFF_PSCNT);

  assign hrdata = q.rdata;
  assign hreadyout = q.ready;
  assign hresp = q.resp;
  assign rtcIrq = q.irq;

  // Two stages: the second counts the first one's overflow
  crt_prescaler #(.W(8)) u_ps0 (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(psTick),
    .divSel(q.div0),
    .load(psLoad),
    .loadVal(hwdata[7:0]),
    .cnt(ps0Cnt),
    .evt(ps0Evt),
    .ovf(ps0Ovf)
  );

  crt_prescaler #(.W(8)) u_ps1 (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(ps0Ovf),
    .divSel(q.div1),
    .load(psLoad),
    .loadVal(hwdata[15:8]),
    .cnt(ps1Cnt),
    .evt(ps1Evt),
    .ovf()
  );

  // Alarm compares in the format software reads
  function automatic logic [7:0] fmt(input logic [11:0] v, input logic b);
    logic [15:0] t;
    t = crt_pkg::crt_bin2bcd(v);
    return b ? t[7:0] : v[7:0];
  endfunction : fmt

  function automatic logic [11:0] unfmt(input logic [15:0] v,
                                        input logic b);
    return b ? crt_pkg::crt_bcd2bin(v) : v[11:0];
  endfunction : unfmt

  always_comb
  begin
    d = q;
    setF = '0;
    minEdge = 1'b0;
    hourEdge = 1'b0;
    // Reference pin synchroniser
    d.osc1 = oscClk;
    d.osc2 = q.osc1;
    d.oscPrev = q.osc2;

    // Calendar roll-over
    if (secTick && calMode)
    begin
      setF.readReady = 1'b1;
      d.cal.sec = q.cal.sec + 6'h01;
      if (q.cal.sec == 6'h3B)
      begin
        d.cal.sec = 6'h00;
        d.cal.min = q.cal.min + 6'h01;
        minEdge = 1'b1;
        if (q.cal.min == 6'h3B)
        begin
          d.cal.min = 6'h00;
          d.cal.hour = q.cal.hour + 5'h01;
          hourEdge = 1'b1;
          if (q.cal.hour == 5'h17)
          begin
            d.cal.hour = 5'h00;
            d.cal.dow = (q.cal.dow == 3'h6) ? 3'h0 : q.cal.dow + 3'h1;
            d.cal.dom = q.cal.dom + 5'h01;
            if (q.cal.dom == crt_pkg::crt_mdays(q.cal.mon, q.cal.year))
            begin
              d.cal.dom = 5'h01;
              d.cal.mon = q.cal.mon + 4'h1;
              if (q.cal.mon == 4'hC)
              begin
                d.cal.mon = 4'h1;
                d.cal.year = q.cal.year + 12'h001;
              end
            end
          end
        end
      end
    end

    // Counter mode: overflow is the time event
    if (secTick && !calMode)
    begin
      d.count = q.count + 32'h0000_0001;
      if (&q.count)
        setF.timeEvent = 1'b1;
    end

    // Selected calendar event
    case (crt_pkg::crt_evt_t'(q.ctrl[crt_pkg::CTRL_EVT +: 2]))
      crt_pkg::EVENT_ON_MINUTE_CHANGE:
        setF.timeEvent = setF.timeEvent || minEdge;
      crt_pkg::EVENT_ON_HOUR_CHANGE:
        setF.timeEvent = setF.timeEvent || hourEdge;
      crt_pkg::EVENT_ON_NOON:
        setF.timeEvent = setF.timeEvent
          || (hourEdge && d.cal.hour == 5'h0C);
      crt_pkg::EVENT_ON_MIDNIGHT:
        setF.timeEvent = setF.timeEvent
          || (hourEdge && d.cal.hour == 5'h00);
      default:
        setF.timeEvent = setF.timeEvent;
    endcase

    // Fields taken after roll-over, inside this process to avoid a loop
    fMin = fmt(12'(d.cal.min), bcd);
    fHour = fmt(12'(d.cal.hour), bcd);
    fDow = fmt(12'(d.cal.dow), bcd);
    fDom = fmt(12'(d.cal.dom), bcd);

    // Alarm: every enabled field must match on the new minute
    almAny = q.alarm[crt_pkg::ALARM_EN] || q.alarm[8+crt_pkg::ALARM_EN]
      || q.alarm[16+crt_pkg::ALARM_EN] || q.alarm[24+crt_pkg::ALARM_EN];
    almHit = almAny
      && (q.alarm[crt_pkg::ALARM_EN] == crt_pkg::ALARM_FIELD_EXCLUDED
        || fMin[6:0] == q.alarm[6:0])
      && (q.alarm[8+crt_pkg::ALARM_EN] == crt_pkg::ALARM_FIELD_EXCLUDED
        || fHour[6:0] == q.alarm[14:8])
      && (q.alarm[16+crt_pkg::ALARM_EN] == crt_pkg::ALARM_FIELD_EXCLUDED
        || fDow[6:0] == q.alarm[22:16])
      && (q.alarm[24+crt_pkg::ALARM_EN] == crt_pkg::ALARM_FIELD_EXCLUDED
        || fDom[6:0] == q.alarm[30:24]);
    setF.alarm = minEdge && almHit;

    // Prescaler events
    setF.prescalerZeroEventFlag = ps0Evt;
    setF.prescalerOneEventFlag = ps1Evt;

    // Fault: reference silent too long while running
    // Held time never counts, so a release cannot trip it at once
    if (oscTick || hold)
      d.faultCnt = 12'h000;
    else if (q.faultCnt != crt_pkg::FAULT_CYC)
      d.faultCnt = q.faultCnt + 12'h001;
    setF.oscFault = !hold && !oscTick
      && (q.faultCnt == crt_pkg::FAULT_CYC - 12'h001);

    // Register writes land in the data phase; they win over counting
    clrF = '0;
    if (wrEn)
    begin
      case (q.dphAddr)
        crt_pkg::OFF_CTRL: d.ctrl = hwdata[7:0];
        crt_pkg::OFF_FLAG: clrF = crt_pkg::crt_flags_t'(hwdata[5:0]);
        crt_pkg::OFF_IEN: d.irqEn = crt_pkg::crt_flags_t'(hwdata[5:0]);
        crt_pkg::OFF_PSCTL:
        begin
          d.div0 = hwdata[2:0];
          d.div1 = hwdata[crt_pkg::PS1_DIV +: 3];
        end
        crt_pkg::OFF_TIME:
        begin
          d.cal.sec = 6'(unfmt({8'h00, hwdata[7:0]}, bcd));
          d.cal.min = 6'(unfmt({8'h00, hwdata[15:8]}, bcd));
          d.cal.hour = 5'(unfmt({8'h00, hwdata[23:16]}, bcd));
          d.cal.dow = 3'(unfmt({8'h00, hwdata[31:24]}, bcd));
        end
        crt_pkg::OFF_DATE:
        begin
          d.cal.dom = 5'(unfmt({8'h00, hwdata[7:0]}, bcd));
          d.cal.mon = 4'(unfmt({8'h00, hwdata[15:8]}, bcd));
          d.cal.year = unfmt(hwdata[31:16], bcd);
        end
        crt_pkg::OFF_ALARM: d.alarm = hwdata;
        crt_pkg::OFF_COUNT: d.count = hwdata;
        default: d.ctrl = q.ctrl;
      endcase
    end

    // Set wins over a clear in the same cycle
    d.flags = crt_pkg::crt_flags_t'((q.flags & ~clrF) | setF);
    d.irq = |(d.flags & d.irqEn);

    // Address phase: latch target, fetch read data from next state, prescaler counts from current state
    d.dphWr = addrPh && hwrite;
    d.dphAddr = haddr[7:0];
    if (addrPh && !hwrite)
    begin
      case (haddr[7:0])
        crt_pkg::OFF_CTRL: d.rdata = {24'h00_0000, d.ctrl};
        crt_pkg::OFF_FLAG: d.rdata = {26'h000_0000, d.flags};
        crt_pkg::OFF_IEN: d.rdata = {26'h000_0000, d.irqEn};
        crt_pkg::OFF_PSCTL:
          d.rdata = {21'h00_0000, d.div1, 5'h00, d.div0};
        crt_pkg::OFF_PSCNT: d.rdata = {16'h0000, ps1Cnt, ps0Cnt};
        crt_pkg::OFF_TIME:
          d.rdata = {fmt(12'(d.cal.dow), bcd), fmt(12'(d.cal.hour), bcd),
            fmt(12'(d.cal.min), bcd), fmt(12'(d.cal.sec), bcd)};
        crt_pkg::OFF_DATE:
          d.rdata = {(bcd ? crt_pkg::crt_bin2bcd(d.cal.year)
            : {4'h0, d.cal.year}), fmt(12'(d.cal.mon), bcd),
            fmt(12'(d.cal.dom), bcd)};
        crt_pkg::OFF_ALARM: d.rdata = d.alarm;
        crt_pkg::OFF_COUNT: d.rdata = d.count;
        crt_pkg::OFF_PEND: d.rdata = {26'h000_0000, d.flags & d.irqEn};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    d.ready = 1'b1;
    d.resp = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      q <= crt_pkg::ST_RST;
    else
      q <= d;
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence calSecS;
    secTick && calMode && !wrEn;
  endsequence

  sequence minuteRollS;
    calSecS ##0 (q.cal.sec == 6'h3B);
  endsequence

  irq_or_a: assert property (
    rtcIrq == |(q.flags & q.irqEn))
    else $error("interrupt differs from set enabled flags");

  flag_sticky_a: assert property (
    q.flags.alarm && !(wrEn && q.dphAddr == crt_pkg::OFF_FLAG)
    |=> q.flags.alarm)
    else $error("alarm flag dropped without a clear");

  flag_clear_a: assert property (
    wrEn && q.dphAddr == crt_pkg::OFF_FLAG && hwdata[0] && !setF.timeEvent
    |=> !q.flags.timeEvent)
    else $error("time event flag survived its clear");

  hold_freeze_a: assert property (
    hold && !wrEn |=> $stable(q.cal) && $stable(q.count))
    else $error("counting moved while held");

  minute_evt_a: assert property (
    minuteRollS ##0 (q.ctrl[crt_pkg::CTRL_EVT +: 2] == 2'h0)
    |=> q.flags.timeEvent)
    else $error("minute change raised no time event");

  noon_evt_a: assert property (
    $rose(q.flags.timeEvent) && $past(calMode) && !$past(wrEn)
    && $past(q.ctrl[crt_pkg::CTRL_EVT +: 2]) == 2'h2
    |-> q.cal.hour == 5'h0C && q.cal.min == 6'h00)
    else $error("noon event at wrong hour");

  alarm_min_a: assert property (
    $rose(q.flags.alarm) && !$past(wrEn) |-> q.cal.sec == 6'h00)
    else $error("alarm off a minute boundary");

  ready_set_a: assert property (
    calSecS |=> q.flags.readReady)
    else $error("read-ready not set after update");

  fault_set_a: assert property (
    !hold && !oscTick && q.faultCnt == crt_pkg::FAULT_CYC - 12'h001
    |=> q.flags.oscFault ##1 q.flags.oscFault)
    else $error("oscillator fault not flagged");

  ovf_evt_a: assert property (
    secTick && !calMode && (&q.count) |=> q.flags.timeEvent)
    else $error("counter overflow raised no time event");

  alarm_cal_a: assert property (
    $rose(q.flags.alarm) |-> $past(calMode))
    else $error("alarm raised outside calendar mode");

  ps_event_a: assert property (
    ps0Evt |=> q.flags.prescalerZeroEventFlag)
    else $error("stage zero event not flagged");

endmodule : crt_rtc

// ==== verilog/crt_pkg.sv ====
// Package: constants, carriers and helpers of the calendar clock
//
// Function
// - Calendar mode keeps running counts of time of day and date.
// - Four calendar events, one counter overflow, one event per prescaler.
// - Time event flag sets on counter overflow or selected calendar event.
// - Alarm flag sets when the alarm condition is met in calendar mode.
// - Read-ready flag sets once calendar registers have settled.
// - First prescaler event flag sets on its configured event condition.
// - Second prescaler event flag sets on its configured event condition.
// - Oscillator fault flag sets on reference fault while clock runs.
// - Each flag has an enable; only enabled flags drive the interrupt.
// - Software clear request clears the selected flags.
// - Per-stage event divider 2 to 256, defaulting to 2.
// - Event divider only picks event timing, not stage counting.
// - Exactly two prescaler stages, each configured and read apart.
// - A calendar event setting fires on every minute change.
// - Alarm fires when all enabled minute, hour, weekday, date fields match.
// - Calendar events: minute change, hour change, noon, midnight.
// - Main hold control stops all clock and calendar counting.
// - Calendar registers read binary or BCD, binary by default.
package crt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FLAG = 8'h04;
  localparam logic [7:0] OFF_IEN = 8'h08;
  localparam logic [7:0] OFF_PSCTL = 8'h0C;
  localparam logic [7:0] OFF_PSCNT = 8'h10;
  localparam logic [7:0] OFF_TIME = 8'h14;
  localparam logic [7:0] OFF_DATE = 8'h18;
  localparam logic [7:0] OFF_ALARM = 8'h1C;
  localparam logic [7:0] OFF_COUNT = 8'h20;
  localparam logic [7:0] OFF_PEND = 8'h24;

  // Control fields
  localparam int CTRL_HOLD = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_BCD = 2;
  localparam int CTRL_EVT = 4;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam int PS1_DIV = 8;
  localparam int ALARM_EN = 7;
  localparam logic ALARM_FIELD_EXCLUDED = 1'b0;

  typedef enum logic [1:0] {
    EVENT_ON_MINUTE_CHANGE = 2'h0,
    EVENT_ON_HOUR_CHANGE = 2'h1,
    EVENT_ON_NOON = 2'h2,
    EVENT_ON_MIDNIGHT = 2'h3
  } crt_evt_t;

  localparam logic [2:0] PRESCALER_EVENT_DIVIDE_BY_TWO = 3'h0;
  localparam logic [2:0] PRESCALER_EVENT_DIVIDE_BY_256 = 3'h7;

  // Seconds tick: second stage low bits all ones
  localparam logic [6:0] SEC_MASK = 7'h7F;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAULT_NS = 100000;
  localparam logic [11:0] FAULT_CYC = 12'(FAULT_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic oscFault;
    logic prescalerOneEventFlag;
    logic prescalerZeroEventFlag;
    logic readReady;
    logic alarm;
    logic timeEvent;
  } crt_flags_t;

  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] dow;
    logic [4:0] dom;
    logic [3:0] mon;
    logic [11:0] year;
  } crt_cal_t;

  localparam crt_cal_t CAL_RST = '{dom: 5'h01, mon: 4'h1, default: '0};

  typedef struct packed {
    logic osc1;
    logic osc2;
    logic oscPrev;
    logic [11:0] faultCnt;
    logic [7:0] ctrl;
    crt_flags_t flags;
    crt_flags_t irqEn;
    logic [2:0] div0;
    logic [2:0] div1;
    crt_cal_t cal;
    logic [31:0] count;
    logic [31:0] alarm;
    logic dphWr;
    logic [7:0] dphAddr;
    logic [31:0] rdata;
    logic irq;
    logic ready;
    logic resp;
  } crt_state_t;

  localparam crt_state_t ST_RST = '{
    ctrl: CTRL_RST,
    cal: CAL_RST,
    ready: 1'b1,
    default: '0
  };

  typedef struct packed {
    logic [7:0] cnt;
  } crt_ps_state_t;

  function automatic logic [15:0] crt_bin2bcd(input logic [11:0] b);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 11; i >= 0; i--)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (r[k*4 +: 4] > 4'h4)
          r[k*4 +: 4] = r[k*4 +: 4] + 4'h3;
      end
      r = {r[14:0], b[i]};
    end
    return r;
  endfunction : crt_bin2bcd

  function automatic logic [11:0] crt_bcd2bin(input logic [15:0] d);
    logic [15:0] r;
    r = 16'(d[15:12]) * 16'h03E8 + 16'(d[11:8]) * 16'h0064
      + 16'(d[7:4]) * 16'h000A + 16'(d[3:0]);
    return r[11:0];
  endfunction : crt_bcd2bin

  function automatic logic [4:0] crt_mdays(input logic [3:0] mon,
                                           input logic [11:0] year);
    case (mon)
      4'h2: return (year[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: return 5'h1E;
      default: return 5'h1F;
    endcase
  endfunction : crt_mdays

endpackage : crt_pkg

// ==== verilog/crt_prescaler.sv ====
// One prescaler stage: 8-bit count with selectable event divider
`timescale 1ns/1ps
module crt_prescaler #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Counting
  input wire logic tick,
  input wire logic [2:0] divSel,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  // Results
  output logic [W-1:0] cnt,
  output logic evt,
  output logic ovf
);

  crt_pkg::crt_ps_state_t q;
  crt_pkg::crt_ps_state_t d;
  logic [W-1:0] mask;

  // Divider only masks the compare; the count runs on regardless
  assign mask = W'((9'h002 << divSel) - 9'h001);
  assign evt = tick && ((q.cnt & mask) == mask);
  assign ovf = tick && (&q.cnt);
  assign cnt = q.cnt;

  always_comb
  begin
    d = q;
    if (load)
      d.cnt = loadVal;
    else if (tick)
      d.cnt = q.cnt + W'(1);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  // Event must fall just before the count reaches a divider multiple
  evt_mask_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    evt && !load |=> (int'(cnt) % (2 << $past(divSel))) == 0)
    else $error("prescaler event off its divider point");
  count_step_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    tick && !load |=> cnt == W'($past(cnt) + W'(1)))
    else $error("prescaler count did not step on tick");

endmodule : crt_prescaler

// ==== verif/crt_osc_model.sv ====
// Reference oscillator model for the slow pin of the calendar clock
`timescale 1ns/1ps
module crt_osc_model #(
  parameter int HALF = 4
) (
  // Clock
  input wire logic core_clk,
  // Control
  input wire logic run,
  // Reference pin
  output logic oscClk
);
  int phase;

  initial
  begin
    oscClk = 1'b0;
    phase = 0;
  end

  // A stopped oscillator sits low, as a dead crystal would
  always @(posedge core_clk)
  begin
    if (!run)
    begin
      oscClk <= 1'b0;
      phase <= 0;
    end
    else if (phase == HALF - 1)
    begin
      oscClk <= ~oscClk;
      phase <= 0;
    end
    else
      phase <= phase + 1;
  end
endmodule : crt_osc_model

// ==== verif/crt_rtc_tb_top.sv ====
// Self-checking bench of the calendar clock block
`timescale 1ns/1ps
module crt_rtc_tb_top;
  logic core_clk;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic oscClk;
  logic oscRun;
  logic rtcIrq;
  logic [31:0] rdv;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  crt_rtc crt_rtc_inst (
    .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .oscClk(oscClk), .rtcIrq(rtcIrq)
  );

  crt_osc_model crt_osc_model_inst (
    .core_clk(core_clk), .run(oscRun), .oscClk(oscClk)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Whole run needs roughly 10k cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      errors++;
      results();
    end
  end

  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0000_0000, rdv);
  endtask : rd

  task pulse(input int n);
    oscRun <= 1'b1;
    repeat (n) @(posedge oscClk);
    oscRun <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : pulse

  // One second tick: prescalers loaded one edge short of rollover
  task secTick(input logic [7:0] ctrl, input logic [31:0] tm,
               input logic [31:0] alm);
    wr(crt_pkg::OFF_CTRL, {24'h00_0000, ctrl | 8'h01});
    wr(crt_pkg::OFF_FLAG, 32'h0000_003F);
    wr(crt_pkg::OFF_TIME, tm);
    wr(crt_pkg::OFF_ALARM, alm);
    wr(crt_pkg::OFF_COUNT, 32'hFFFF_FFFF);
    wr(crt_pkg::OFF_PSCNT, 32'h0000_7FFF);
    wr(crt_pkg::OFF_CTRL, {24'h00_0000, ctrl});
    pulse(1);
    wr(crt_pkg::OFF_CTRL, {24'h00_0000, ctrl | 8'h01});
  endtask : secTick

  task checkReset;
    rd(crt_pkg::OFF_CTRL);
    check("control", rdv, 32'h0000_0001);
    rd(crt_pkg::OFF_FLAG);
    check("flags", rdv, 32'h0000_0000);
    rd(crt_pkg::OFF_PSCTL);
    check("dividers", rdv, 32'h0000_0000);
    rd(crt_pkg::OFF_DATE);
    check("date", rdv, 32'h0000_0101);
    rd(crt_pkg::OFF_ALARM);
    check("alarm", rdv, 32'h0000_0000);
    rd(8'h30);
    check("unmapped", rdv, 32'h0000_0000);
    check("response", {31'h0, hresp}, 32'h0000_0000);
    wr(crt_pkg::OFF_DATE, 32'h07E4_0C1F);
    rd(crt_pkg::OFF_DATE);
    check("date set", rdv, 32'h07E4_0C1F);
  endtask : checkReset

  task checkPrescale;
    wr(crt_pkg::OFF_PSCTL, 32'h0000_0701);
    wr(crt_pkg::OFF_PSCNT, 32'h0000_0000);
    wr(crt_pkg::OFF_FLAG, 32'h0000_003F);
    wr(crt_pkg::OFF_CTRL, 32'h0000_0000);
    pulse(2);
    wr(crt_pkg::OFF_CTRL, 32'h0000_0001);
    rd(crt_pkg::OFF_FLAG);
    check("stage0 early", {31'h0, rdv[3]}, 32'h0000_0000);
    rd(crt_pkg::OFF_PSCNT);
    check("stage count", rdv, 32'h0000_0002);
    wr(crt_pkg::OFF_CTRL, 32'h0000_0000);
    pulse(2);
    wr(crt_pkg::OFF_CTRL, 32'h0000_0001);
    rd(crt_pkg::OFF_FLAG);
    check("stage0 event", {31'h0, rdv[3]}, 32'h0000_0001);
    pulse(3);
    rd(crt_pkg::OFF_PSCNT);
    check("held count", rdv, 32'h0000_0004);
    wr(crt_pkg::OFF_PSCNT, 32'h0000_FEFF);
    wr(crt_pkg::OFF_FLAG, 32'h0000_003F);
    wr(crt_pkg::OFF_CTRL, 32'h0000_0000);
    pulse(257);
    wr(crt_pkg::OFF_CTRL, 32'h0000_0001);
    rd(crt_pkg::OFF_FLAG);
    check("stage1 event", {31'h0, rdv[4]}, 32'h0000_0001);
    rd(crt_pkg::OFF_PSCNT);
    check("both counts", rdv, 32'h0000_0000);
  endtask : checkPrescale

  task checkEvents;
    logic [1:0] code [6];
    logic [7:0] hr [6];
    logic hit [6];
    logic [7:0] nh;
    code = '{crt_pkg::EVENT_ON_MINUTE_CHANGE, crt_pkg::EVENT_ON_HOUR_CHANGE,
             crt_pkg::EVENT_ON_NOON, crt_pkg::EVENT_ON_NOON,
             crt_pkg::EVENT_ON_MIDNIGHT, crt_pkg::EVENT_ON_MIDNIGHT};
    hr = '{8'h03, 8'h03, 8'h03, 8'h0B, 8'h0B, 8'h17};
    hit = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 6; i++)
    begin
      secTick({2'h0, code[i], 4'h0}, {8'h00, hr[i], 16'h3B3B},
              32'h0000_0000);
      rd(crt_pkg::OFF_FLAG);
      check("time event", 32'(rdv[0]), 32'(hit[i]));
      nh = (hr[i] == 8'h17) ? 8'h00 : hr[i] + 8'h01;
      rd(crt_pkg::OFF_TIME);
      check("time", rdv, {7'h0, hr[i] == 8'h17, nh, 16'h0000});
    end
    rd(crt_pkg::OFF_DATE);
    check("date wrap", rdv, 32'h07E5_0101);
  endtask : checkEvents

  task checkIrq;
    wr(crt_pkg::OFF_FLAG, 32'h0000_003E);
    wr(crt_pkg::OFF_IEN, 32'h0000_003E);
    repeat (2) @(posedge core_clk);
    check("irq masked", {31'h0, rtcIrq}, 32'h0000_0000);
    wr(crt_pkg::OFF_IEN, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    check("irq on", {31'h0, rtcIrq}, 32'h0000_0001);
    repeat (20) @(posedge core_clk);
    check("irq held", {31'h0, rtcIrq}, 32'h0000_0001);
    rd(crt_pkg::OFF_PEND);
    check("pending", rdv, 32'h0000_0001);
    wr(crt_pkg::OFF_FLAG, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    check("irq cleared", {31'h0, rtcIrq}, 32'h0000_0000);
    rd(crt_pkg::OFF_FLAG);
    check("flag cleared", {31'h0, rdv[0]}, 32'h0000_0000);
    wr(crt_pkg::OFF_IEN, 32'h0000_0000);
  endtask : checkIrq

  // Clock goes 03:59:59 to 04:00:00, day of week stays 0
  task checkAlarm;
    logic [31:0] alm [5];
    logic hit [5];
    alm = '{32'h0000_8480, 32'h0000_8580, 32'h0000_0000, 32'h0080_8480,
            32'h0081_8480};
    hit = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      secTick(8'h00, 32'h0003_3B3B, alm[i]);
      rd(crt_pkg::OFF_FLAG);
      check("alarm", {31'h0, rdv[1]}, {31'h0, hit[i]});
    end
  endtask : checkAlarm

  task checkModes;
    secTick(8'h04, 32'h0009_5959, 32'h0000_0000);
    rd(crt_pkg::OFF_TIME);
    check("bcd time", rdv, 32'h0010_0000);
    secTick(8'h02, 32'h0000_0000, 32'h0000_0000);
    rd(crt_pkg::OFF_COUNT);
    check("counter wrap", rdv, 32'h0000_0000);
    rd(crt_pkg::OFF_FLAG);
    check("overflow", {31'h0, rdv[0]}, 32'h0000_0001);
  endtask : checkModes

  // Fault window is 2500 cycles without an edge
  task checkFault;
    wr(crt_pkg::OFF_FLAG, 32'h0000_003F);
    wr(crt_pkg::OFF_CTRL, 32'h0000_0000);
    repeat (2600) @(posedge core_clk);
    wr(crt_pkg::OFF_CTRL, 32'h0000_0001);
    rd(crt_pkg::OFF_FLAG);
    check("osc fault", {31'h0, rdv[5]}, 32'h0000_0001);
    wr(crt_pkg::OFF_FLAG, 32'h0000_003F);
    repeat (2600) @(posedge core_clk);
    rd(crt_pkg::OFF_FLAG);
    check("fault held", {31'h0, rdv[5]}, 32'h0000_0000);
  endtask : checkFault

  initial
  begin
    rstn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0000_0000;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0000_0000;
    oscRun <= 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    checkReset();
    checkPrescale();
    checkEvents();
    checkIrq();
    checkAlarm();
    checkModes();
    checkFault();
    results();
  end
endmodule : crt_rtc_tb_top
